// File: mac_consts.vh
// Constants for the four-axis motion configuration and control block.
// Assumes inclusion by mac_axis_ctrl.v; holds definitions only.
`ifndef MAC_CONSTS_VH
`define MAC_CONSTS_VH

// ----------------------------------------
// Board registers, paddr[11:0]
// ----------------------------------------
`define MAC_SW_POL 12'h000
`define MAC_SW_EN 12'h004
`define MAC_IO_DIR 12'h008
`define MAC_IO_POL 12'h00C
`define MAC_IO_OUT 12'h010
`define MAC_IO_TRIG 12'h014
`define MAC_IO_IN 12'h018
`define MAC_STEP_CFG 12'h01C
`define MAC_TRIG_ST 12'h020
`define MAC_SW_POL_RST 12'h000
`define MAC_SW_EN_RST 12'h000
`define MAC_STEP_CFG_RST 16'h0000

// ----------------------------------------
// Axis registers: paddr[11:8]=1, [7:6]=axis
// ----------------------------------------
`define MAC_AX_BASE 4'h1
`define MAC_A_MODE 6'h00
`define MAC_A_TGT 6'h04
`define MAC_A_VEL 6'h08
`define MAC_A_ACC 6'h0C
`define MAC_A_FERR 6'h10
`define MAC_A_KP 6'h14
`define MAC_A_FILT 6'h18
`define MAC_A_CMD 6'h1C
`define MAC_A_POS 6'h20
`define MAC_A_ENC 6'h24
`define MAC_A_STAT 6'h28
`define MAC_A_IOFF 6'h2C

// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define MAC_M_ABS 2'h0
`define MAC_M_REL 2'h1
`define MAC_M_VEL 2'h2
`define MAC_C_START 0
`define MAC_C_STOP 1
`define MAC_C_KILL 2
`define MAC_C_HOME 3
`define MAC_C_INDEX 4
`define MAC_C_RSTPOS 5
`define MAC_C_REV 6
`define MAC_SPD_MIN 32'h0001_0000
`define MAC_REV_COUNTS 32'h0000_07D0

`endif

// File: mac_axis_ctrl.v
// Four-axis motion configuration and control with an APB register slave.
// Assumes one 10 MHz clock; switch, encoder and I/O pins are asynchronous.
`timescale 1ns/1ns
`include "mac_consts.vh"

module mac_axis_ctrl #(
  parameter STEPPER = 0,
  parameter [31:0] REV_COUNTS = `MAC_REV_COUNTS
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire [3:0] lim_fwd,
  input wire [3:0] lim_rev,
  input wire [3:0] home_sw,
  input wire [3:0] enc_a,
  input wire [3:0] enc_b,
  input wire [3:0] enc_idx,
  input wire [7:0] io_in,
  output reg [7:0] io_o,
  output reg [7:0] io_oe,
  output wire [3:0] step_a,
  output wire [3:0] step_b,
  output wire [3:0] step_inh,
  output wire [3:0] drive_en,
  output wire [63:0] motor_drive
);

  localparam [2:0] S_KILL = 3'h0;
  localparam [2:0] S_HOLD = 3'h1;
  localparam [2:0] S_MOVE = 3'h2;
  localparam [2:0] S_VEL = 3'h3;
  localparam [2:0] S_HOME = 3'h4;
  localparam [2:0] S_INDEX = 3'h5;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Bits: fwd 0-3, rev 4-7, home 8-11, a 12-15, b 16-19, idx 20-23, io 24-31
  wire [31:0] pin_raw = {io_in, enc_idx, enc_b, enc_a, home_sw, lim_rev, lim_fwd};
  reg [31:0] s1_r;
  reg [31:0] s2_r;
  reg [31:0] s3_r;
  reg [31:0] pin_r;
  wire [31:0] agree = s2_r ~^ s3_r;

  // A change is accepted only once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 32'h0;
      s2_r <= 32'h0;
      s3_r <= 32'h0;
      pin_r <= 32'h0;
    end else if (ce) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (pin_r & ~agree) | (s3_r & agree);
    end
  end

  // ----------------------------------------
  // APB access and board registers
  // ----------------------------------------
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire brd = (paddr[11:8] == 4'h0);
  reg [11:0] sw_pol_r;
  reg [11:0] sw_en_r;
  reg [7:0] io_dir_r;
  reg [7:0] io_pol_r;
  reg [7:0] io_out_r;
  reg [7:0] io_trig_r;
  reg [15:0] step_cfg_r;
  reg [7:0] trig_st_r;
  reg [7:0] in_p_r;
  wire [3:0] inh_w;
  wire [31:0] ax_rd [0:3];
  wire [3:0] ax_hit;

  // Switch active when enabled and level matches sense (pol 0 = low active)
  wire [11:0] sw_act = sw_en_r & ~(pin_r[11:0] ^ sw_pol_r);
  wire [7:0] in_val = pin_r[31:24] ^ io_pol_r;
  wire [7:0] gen_msk = (STEPPER != 0) ? 8'h0F : 8'hFF;
  wire [7:0] trig_ev = io_trig_r & ~io_dir_r & in_val & ~in_p_r & gen_msk;
  wire [7:0] gen_o = io_out_r ^ io_pol_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_pol_r <= `MAC_SW_POL_RST;
      sw_en_r <= `MAC_SW_EN_RST;
      io_dir_r <= 8'h00;
      io_pol_r <= 8'h00;
      io_out_r <= 8'h00;
      io_trig_r <= 8'h00;
      step_cfg_r <= `MAC_STEP_CFG_RST;
      trig_st_r <= 8'h00;
      in_p_r <= 8'h00;
      io_o <= 8'h00;
      io_oe <= 8'h00;
    end else if (ce) begin
      in_p_r <= in_val;
      if (wr & brd) begin
        case (paddr)
          `MAC_SW_POL: sw_pol_r <= pwdata[11:0];
          `MAC_SW_EN: sw_en_r <= pwdata[11:0];
          `MAC_IO_DIR: io_dir_r <= pwdata[7:0];
          `MAC_IO_POL: io_pol_r <= pwdata[7:0];
          `MAC_IO_OUT: io_out_r <= pwdata[7:0];
          `MAC_IO_TRIG: io_trig_r <= pwdata[7:0];
          `MAC_STEP_CFG: step_cfg_r <= pwdata[15:0];
          default: ;
        endcase
      end
      // New trigger events win over a write-one clear in the same cycle
      if (wr & brd & (paddr == `MAC_TRIG_ST)) begin
        trig_st_r <= (trig_st_r & ~pwdata[7:0]) | trig_ev;
      end else begin
        trig_st_r <= trig_st_r | trig_ev;
      end
      if (STEPPER != 0) begin
        io_o <= {inh_w, gen_o[3:0]};
        io_oe <= {4'hF, io_dir_r[3:0]};
      end else begin
        io_o <= gen_o;
        io_oe <= io_dir_r;
      end
    end
  end

  reg [31:0] rd_nxt;
  reg hit_nxt;
  always @* begin
    rd_nxt = 32'h0;
    hit_nxt = brd;
    case (paddr)
      `MAC_SW_POL: rd_nxt = {20'h0, sw_pol_r};
      `MAC_SW_EN: rd_nxt = {20'h0, sw_en_r};
      `MAC_IO_DIR: rd_nxt = {24'h0, io_dir_r};
      `MAC_IO_POL: rd_nxt = {24'h0, io_pol_r};
      `MAC_IO_OUT: rd_nxt = {24'h0, io_out_r};
      `MAC_IO_TRIG: rd_nxt = {24'h0, io_trig_r};
      `MAC_IO_IN: rd_nxt = {24'h0, in_val & gen_msk};
      `MAC_STEP_CFG: rd_nxt = {16'h0, step_cfg_r};
      `MAC_TRIG_ST: rd_nxt = {24'h0, trig_st_r};
      default: hit_nxt = 1'b0;
    endcase
    if (paddr[11:8] == `MAC_AX_BASE) begin
      rd_nxt = ax_rd[paddr[7:6]];
      hit_nxt = ax_hit[paddr[7:6]];
    end
  end

  // Answer one cycle after setup: no wait beyond the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0 : rd_nxt;
        pslverr <= ~hit_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Per-axis control
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : ax
      localparam [1:0] IX = i;
      wire wsel = wr & (paddr[11:8] == `MAC_AX_BASE) & (paddr[7:6] == IX);
      wire cmd = wsel & (paddr[5:0] == `MAC_A_CMD);
      reg [2:0] mode_r;
      reg [31:0] tgt_r;
      reg [15:0] vel_r;
      reg [15:0] acc_r;
      reg [15:0] ferr_r;
      reg [15:0] kp_r;
      reg [31:0] filt_r;
      reg [15:0] ioff_r;
      reg [31:0] pos_r;
      reg [31:0] dest_r;
      reg [31:0] enc_r;
      reg [31:0] spd_r;
      reg [15:0] ph_r;
      reg [31:0] ramp_r;
      reg [31:0] rev_r;
      reg [15:0] run_vel_r;
      reg [2:0] st_r;
      reg dir_r;
      reg ftrip_r;
      reg shalt_r;
      reg qa_r;
      reg qb_r;
      reg qi_r;
      reg sa_r;
      reg sb_r;
      reg si_r;
      reg [15:0] drv_r;

      wire a = pin_r[12+i];
      wire b = pin_r[16+i];
      wire x = pin_r[20+i];
      wire qd_chg = (a ^ qa_r) ^ (b ^ qb_r);
      wire qd_up = qa_r ^ b;
      wire idx_edge = x & ~qi_r;
      wire moving = (st_r == S_MOVE) | (st_r == S_VEL) | (st_r == S_HOME) |
                    (st_r == S_INDEX);
      wire sw_hit = sw_act[i] | sw_act[4+i] | sw_act[8+i];
      wire home_ok = sw_en_r[i] & sw_en_r[4+i] & sw_en_r[8+i];
      wire [31:0] rem = dir_r ? (pos_r - dest_r) : (dest_r - pos_r);
      wire vel_live = (STEPPER != 0) & (mode_r[1:0] == `MAC_M_VEL);
      wire [15:0] vt = vel_live ? vel_r : run_vel_r;
      wire [31:0] vt32 = {vt, 16'h0};
      wire [31:0] acc32 = {16'h0, acc_r};
      wire [31:0] up = spd_r + acc32;
      wire [31:0] up_lim = (up > vt32) ? vt32 : up;
      wire [31:0] dn = (spd_r > (acc32 + `MAC_SPD_MIN)) ? (spd_r - acc32) : `MAC_SPD_MIN;
      wire [16:0] ph_sum = {1'b0, ph_r} + {1'b0, spd_r[31:16]};
      wire stp = ph_sum[16] & moving & ~((st_r == S_MOVE) & (rem == 32'h0));
      wire decel = (st_r == S_MOVE) & (rem <= ramp_r);
      wire [31:0] err = pos_r - enc_r;
      wire [31:0] aerr = err[31] ? (32'h0 - err) : err;
      wire fchk = (STEPPER == 0) | (ferr_r != 16'h0);
      wire trip = fchk & (st_r != S_KILL) & (aerr > {16'h0, ferr_r});
      wire e_ok = (err[31:15] == 17'h00000) | (err[31:15] == 17'h1FFFF);
      wire [15:0] e16 = e_ok ? err[15:0] : (err[31] ? 16'h8000 : 16'h7FFF);
      wire signed [32:0] prod = $signed(e16) * $signed({1'b0, kp_r});
      wire p_ok = (prod[32:23] == 10'h000) | (prod[32:23] == 10'h3FF);
      wire [15:0] drv = p_ok ? prod[23:8] : (prod[32] ? 16'h8000 : 16'h7FFF);
      wire cw = step_cfg_r[i];
      wire killed = (st_r == S_KILL);

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_r <= 3'h0;
          tgt_r <= 32'h0;
          vel_r <= 16'h0;
          acc_r <= 16'h0;
          ferr_r <= 16'h0;
          kp_r <= 16'h0;
          filt_r <= 32'h0;
          ioff_r <= 16'h0;
          pos_r <= 32'h0;
          dest_r <= 32'h0;
          enc_r <= 32'h0;
          spd_r <= 32'h0;
          ph_r <= 16'h0;
          ramp_r <= 32'h0;
          rev_r <= 32'h0;
          run_vel_r <= 16'h0;
          st_r <= S_KILL;
          dir_r <= 1'b0;
          ftrip_r <= 1'b0;
          shalt_r <= 1'b0;
          qa_r <= 1'b0;
          qb_r <= 1'b0;
          qi_r <= 1'b0;
          sa_r <= 1'b0;
          sb_r <= 1'b0;
          si_r <= 1'b0;
          drv_r <= 16'h0;
        end else if (ce) begin
          qa_r <= a;
          qb_r <= b;
          qi_r <= x;
          if (qd_chg) begin
            enc_r <= qd_up ? enc_r + 32'h1 : enc_r - 32'h1;
          end
          if (wsel) begin
            case (paddr[5:0])
              `MAC_A_MODE: mode_r <= pwdata[2:0];
              `MAC_A_TGT: tgt_r <= (mode_r[1:0] == `MAC_M_REL) ?
                                  pos_r + pwdata : pwdata;
              `MAC_A_VEL: vel_r <= pwdata[15:0];
              `MAC_A_ACC: acc_r <= pwdata[15:0];
              `MAC_A_FERR: ferr_r <= pwdata[15:0];
              `MAC_A_KP: kp_r <= pwdata[15:0];
              `MAC_A_FILT: filt_r <= pwdata;
              `MAC_A_IOFF: ioff_r <= pwdata[15:0];
              default: ;
            endcase
          end
          // Profile: ramp up to velocity, ramp down over the same step count
          if (moving) begin
            ph_r <= ph_sum[15:0];
            spd_r <= decel ? dn : up_lim;
            if (stp) begin
              pos_r <= dir_r ? pos_r - 32'h1 : pos_r + 32'h1;
              rev_r <= rev_r + 32'h1;
              if (decel) begin
                ramp_r <= (ramp_r != 32'h0) ? ramp_r - 32'h1 : 32'h0;
              end else if (spd_r < vt32) begin
                ramp_r <= ramp_r + 32'h1;
              end
            end
          end
          case (st_r)
            S_MOVE: begin
              if (rem == 32'h0) begin
                st_r <= S_HOLD;
                spd_r <= 32'h0;
                ramp_r <= 32'h0;
              end
            end
            S_INDEX: begin
              if (idx_edge) begin
                dest_r <= pos_r + {{16{ioff_r[15]}}, ioff_r};
                dir_r <= ioff_r[15];
                st_r <= S_MOVE;
                spd_r <= 32'h0;
                ramp_r <= 32'h0;
              end else if (rev_r >= REV_COUNTS) begin
                st_r <= S_HOLD;
                dest_r <= pos_r;
                spd_r <= 32'h0;
              end
            end
            default: ;
          endcase
          // Abrupt halt: destination snaps to present position
          if (moving & sw_hit) begin
            st_r <= S_HOLD;
            dest_r <= pos_r;
            spd_r <= 32'h0;
            ramp_r <= 32'h0;
            ph_r <= 16'h0;
            shalt_r <= 1'b1;
          end
          if (cmd & pwdata[`MAC_C_RSTPOS] & ~moving) begin
            pos_r <= 32'h0;
            enc_r <= 32'h0;
            dest_r <= 32'h0;
          end
          if (cmd & pwdata[`MAC_C_START]) begin
            ftrip_r <= 1'b0;
            shalt_r <= 1'b0;
            if (mode_r[1:0] == `MAC_M_VEL) begin
              st_r <= S_VEL;
              dir_r <= mode_r[2];
              run_vel_r <= vel_r;
            end else begin
              st_r <= S_MOVE;
              dest_r <= tgt_r;
              dir_r <= $signed(tgt_r) < $signed(pos_r);
              run_vel_r <= vel_r;
            end
          end else if (cmd & pwdata[`MAC_C_HOME] & home_ok) begin
            st_r <= S_HOME;
            dir_r <= pwdata[`MAC_C_REV];
            run_vel_r <= vel_r;
            shalt_r <= 1'b0;
          end else if (cmd & pwdata[`MAC_C_INDEX]) begin
            st_r <= S_INDEX;
            dir_r <= pwdata[`MAC_C_REV];
            run_vel_r <= vel_r;
            rev_r <= 32'h0;
          end
          if (trip) begin
            st_r <= S_KILL;
            spd_r <= 32'h0;
            ftrip_r <= 1'b1;
          end
          // Stop is a halt; from killed it re-energises and holds in place
          if (cmd & pwdata[`MAC_C_STOP]) begin
            st_r <= S_HOLD;
            dest_r <= pos_r;
            spd_r <= 32'h0;
            ramp_r <= 32'h0;
          end
          if (cmd & pwdata[`MAC_C_KILL]) begin
            st_r <= S_KILL;
            spd_r <= 32'h0;
            ramp_r <= 32'h0;
          end
          // Step outputs: step/dir or pulse pair per mode, each line with its polarity
          sa_r <= (cw ? (stp & ~dir_r) : stp) ^ step_cfg_r[4+i];
          sb_r <= (cw ? (stp & dir_r) : dir_r) ^ step_cfg_r[8+i];
          si_r <= step_cfg_r[12+i] ? killed : ~killed;
          drv_r <= ((STEPPER == 0) & ~killed) ? drv : 16'h0;
        end
      end

      reg [31:0] rd;
      reg rh;
      always @* begin
        rd = 32'h0;
        rh = 1'b1;
        case (paddr[5:0])
          `MAC_A_MODE: rd = {29'h0, mode_r};
          `MAC_A_TGT: rd = tgt_r;
          `MAC_A_VEL: rd = {16'h0, vel_r};
          `MAC_A_ACC: rd = {16'h0, acc_r};
          `MAC_A_FERR: rd = {16'h0, ferr_r};
          `MAC_A_KP: rd = {16'h0, kp_r};
          `MAC_A_FILT: rd = filt_r;
          `MAC_A_CMD: rd = 32'h0;
          `MAC_A_POS: rd = pos_r;
          `MAC_A_ENC: rd = enc_r;
          `MAC_A_STAT: rd = {26'h0, shalt_r, ftrip_r, dir_r, st_r};
          `MAC_A_IOFF: rd = {16'h0, ioff_r};
          default: rh = 1'b0;
        endcase
      end

      assign ax_rd[i] = rd;
      assign ax_hit[i] = rh;
      assign inh_w[i] = si_r;
      assign step_a[i] = sa_r;
      assign step_b[i] = sb_r;
      assign step_inh[i] = si_r;
      assign drive_en[i] = ~killed;
      assign motor_drive[16*i+15:16*i] = drv_r;
    end
  endgenerate

endmodule // mac_axis_ctrl

// File: mac_axis_ctrl_props.sv
// Checker for mac_axis_ctrl: APB timing, switch halt, inhibit and I/O direction.
// Assumes it is bound to mac_axis_ctrl and sees only its ports.
`timescale 1ns/1ns
`include "mac_consts.vh"
module mac_axis_ctrl_props #(
  parameter STEPPER = 0
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [3:0] lim_fwd,
  input wire [3:0] step_a,
  input wire [3:0] step_inh,
  input wire [3:0] drive_en,
  input wire [7:0] io_oe
);
  reg [11:0] pol_r;
  reg [11:0] en_r;
  reg [15:0] cfg_r;
  reg [7:0] dir_r;
  reg [3:0] hcnt_r;
  wire wr_acc = psel && penable && pready && pwrite && ce;
  // Pin level against the programmed sense; unsynced, so the count allows slack
  wire sw_on = (lim_fwd[0] ~^ pol_r[0]) && en_r[0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= `MAC_SW_POL_RST;
      en_r <= `MAC_SW_EN_RST;
      cfg_r <= `MAC_STEP_CFG_RST;
      dir_r <= 8'h00;
      hcnt_r <= 4'h0;
    end else begin
      if (wr_acc && paddr == `MAC_SW_POL) pol_r <= pwdata[11:0];
      if (wr_acc && paddr == `MAC_SW_EN) en_r <= pwdata[11:0];
      if (wr_acc && paddr == `MAC_STEP_CFG) cfg_r <= pwdata[15:0];
      if (wr_acc && paddr == `MAC_IO_DIR) dir_r <= pwdata[7:0];
      hcnt_r <= !sw_on ? 4'h0 : (hcnt_r == 4'hF ? hcnt_r : hcnt_r + 4'h1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_setup_ready: assert property (psel && !penable && ce |=> pready)
    else $error("no answer after setup");
  chk_ready_single: assert property (pready && ce |=> !pready)
    else $error("answer held too long");
  chk_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data on a write");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without answer");
  chk_unmapped_err: assert property (psel && !penable && ce && paddr[11:8] == 4'h0 &&
    paddr[7:0] > 8'h20 && paddr[1:0] == 2'b00 |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped address accepted");
  chk_switch_halt: assert property (hcnt_r >= 4'hA |-> step_a[0] == cfg_r[4])
    else $error("steps continue past switch");
  chk_inhibit_killed: assert property (($stable(cfg_r) && drive_en == 4'h0) [*3] |->
    step_inh == cfg_r[15:12])
    else $error("inhibit not asserted while killed");
  chk_io_dir: assert property ($stable(dir_r) [*3] |->
    io_oe == (dir_r | (STEPPER ? 8'hF0 : 8'h00)))
    else $error("pin enable differs from direction");

  cover property (wr_acc);
  cover property (pslverr);
  cover property (hcnt_r == 4'hA);
endmodule // mac_axis_ctrl_props

bind mac_axis_ctrl mac_axis_ctrl_props #(.STEPPER(STEPPER)) u_props (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .lim_fwd(lim_fwd), .step_a(step_a), .step_inh(step_inh), .drive_en(drive_en),
  .io_oe(io_oe));

// File: mac_drv_model.sv
// Stepper driver plus encoder model: counts step pulses into quadrature.
// Assumes step/dir mode with active-high lines (reset setting).
`timescale 1ns/1ns
module mac_drv_model #(
  parameter [31:0] REV = 32'h0000_0014
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] step,
  input wire [3:0] dir,
  output wire [3:0] enc_a,
  output wire [3:0] enc_b,
  output wire [3:0] enc_idx
);
  reg [31:0] cnt_r [0:3];
  integer i;
  genvar g;

  always @(posedge clk or negedge rst_n) begin
    for (i = 0; i < 4; i = i + 1) begin
      if (!rst_n) cnt_r[i] <= 32'h0000_0000;
      else if (step[i]) cnt_r[i] <= dir[i] ? cnt_r[i] - 1 : cnt_r[i] + 1;
    end
  end

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_enc
      assign enc_a[g] = cnt_r[g][1];
      assign enc_b[g] = cnt_r[g][1] ^ cnt_r[g][0];
      assign enc_idx[g] = (cnt_r[g] % REV) == 32'h0000_0000;
    end
  endgenerate
endmodule // mac_drv_model

// File: mac_axis_ctrl_tb_top.sv
// Testbench for mac_axis_ctrl in its stepper build, driven over APB.
// Assumes mac_drv_model turns the step lines into encoder feedback.
`timescale 1ns/1ns
`include "mac_consts.vh"
module mac_axis_ctrl_tb_top;
  reg pclk, presetn, ce, psel, penable, pwrite, err;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd, p;
  reg [3:0] lim_fwd, lim_rev, home_sw;
  reg [7:0] io_in;
  wire pready, pslverr;
  wire [31:0] prdata;
  wire [3:0] enc_a, enc_b, enc_idx, step_a, step_b, step_inh, drive_en;
  wire [7:0] io_o, io_oe;
  integer n_fail, num_checks, k;

  mac_axis_ctrl #(.STEPPER(1), .REV_COUNTS(32'h0000_0014)) i_dut (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lim_fwd(lim_fwd), .lim_rev(lim_rev), .home_sw(home_sw),
    .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx), .io_in(io_in), .io_o(io_o),
    .io_oe(io_oe), .step_a(step_a), .step_b(step_b), .step_inh(step_inh),
    .drive_en(drive_en), .motor_drive());
  mac_drv_model #(.REV(32'h0000_0014)) i_drv (.clk(pclk), .rst_n(presetn),
    .step(step_a), .dir(step_b), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function [11:0] ax(input [1:0] i, input [5:0] o);
    ax = {`MAC_AX_BASE, i, o};
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  // One transfer, then an idle cycle so back-to-back calls never clash
  task apb(input wr, input [11:0] a, input [31:0] d);
    integer t;
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && t < 50) begin
        @(posedge pclk);
        t = t + 1;
      end
      if (t == 50) n_fail = n_fail + 1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task poll(input [11:0] a, input [31:0] m, input [31:0] e, input [15:0] n);
    integer t;
    begin
      t = 0;
      apb(1'b0, a, 32'h0);
      while ((rd & m) !== e && t < n) begin
        apb(1'b0, a, 32'h0);
        t = t + 1;
      end
      chk(rd & m, e);
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    n_fail = n_fail + 1;
    stop_test;
  end

  initial begin
    n_fail = 0;
    num_checks = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lim_fwd = 4'hF;
    lim_rev = 4'hF;
    home_sw = 4'hF;
    io_in = 8'hA5;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(drive_en, 32'h0);
    poll(`MAC_SW_POL, 32'hFFF, 32'h0, 0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(err, 32'h1);
    for (k = 0; k < 4; k = k + 1) begin
      apb(1'b1, ax(k[1:0], `MAC_A_MODE), k % 3);
    end
    for (k = 0; k < 4; k = k + 1) begin
      poll(ax(k[1:0], `MAC_A_MODE), 32'h3, k % 3, 0);
    end
    // Slow cruise reached before the first step: no step in a ramp, no crawl
    apb(1'b1, ax(0, `MAC_A_VEL), 32'h0000_0100);
    apb(1'b1, ax(0, `MAC_A_ACC), 32'h0000_FFFF);
    apb(1'b1, ax(0, `MAC_A_TGT), 32'h0000_0008);
    apb(1'b1, ax(0, `MAC_A_CMD), 32'h1);
    poll(ax(0, `MAC_A_POS), 32'hFFFF_FFFF, 32'h0000_0008, 1000);
    chk(drive_en, 32'h1);
    poll(ax(0, `MAC_A_ENC), 32'hFFFF_FFFF, 32'h0000_0008, 20);
    apb(1'b1, ax(0, `MAC_A_MODE), `MAC_M_REL);
    apb(1'b1, ax(0, `MAC_A_TGT), 32'h0000_0005);
    apb(1'b1, ax(0, `MAC_A_CMD), 32'h1);
    poll(ax(0, `MAC_A_POS), 32'hFFFF_FFFF, 32'h0000_000D, 1000);
    apb(1'b1, `MAC_SW_EN, 32'h1);
    apb(1'b1, ax(0, `MAC_A_MODE), `MAC_M_VEL);
    apb(1'b1, ax(0, `MAC_A_CMD), 32'h1);
    poll(ax(0, `MAC_A_STAT), 32'h7, 32'h3, 200);
    // Clock enable low: a free-running axis would take several steps here
    apb(1'b0, ax(0, `MAC_A_POS), 32'h0);
    p = rd;
    ce <= 1'b0;
    repeat (1000) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, ax(0, `MAC_A_POS), 32'h0);
    chk(rd - p <= 32'h1, 32'h1);
    lim_fwd <= 4'hE;
    poll(ax(0, `MAC_A_STAT), 32'h27, 32'h21, 20);
    apb(1'b0, ax(0, `MAC_A_POS), 32'h0);
    p = rd;
    poll(ax(0, `MAC_A_POS), 32'hFFFF_FFFF, p, 0);
    apb(1'b1, ax(0, `MAC_A_CMD), 32'h8);
    poll(ax(0, `MAC_A_STAT), 32'h7, 32'h1, 0);
    lim_fwd <= 4'hF;
    apb(1'b1, `MAC_SW_EN, 32'h111);
    apb(1'b1, ax(0, `MAC_A_CMD), 32'h8);
    poll(ax(0, `MAC_A_STAT), 32'h7, 32'h4, 20);
    apb(1'b1, ax(0, `MAC_A_CMD), 32'h4);
    poll(ax(0, `MAC_A_STAT), 32'h7, 32'h0, 20);
    // Park midway between index marks so the search stays inside one turn
    apb(1'b0, ax(0, `MAC_A_POS), 32'h0);
    p = rd;
    apb(1'b1, ax(0, `MAC_A_MODE), `MAC_M_REL);
    apb(1'b1, ax(0, `MAC_A_TGT), (32'h1E - p % 32'h14) % 32'h14);
    apb(1'b1, ax(0, `MAC_A_CMD), 32'h1);
    poll(ax(0, `MAC_A_POS), 32'hFFFF_FFFF, p + (32'h1E - p % 32'h14) % 32'h14, 3000);
    p = rd;
    apb(1'b1, ax(0, `MAC_A_IOFF), 32'h3);
    apb(1'b1, ax(0, `MAC_A_CMD), 32'h10);
    poll(ax(0, `MAC_A_POS), 32'hFFFF_FFFF, p + 32'hD, 3000);
    poll(ax(0, `MAC_A_STAT), 32'h7, 32'h1, 20);
    apb(1'b1, `MAC_IO_DIR, 32'h03);
    apb(1'b1, `MAC_IO_POL, 32'h09);
    apb(1'b1, `MAC_IO_OUT, 32'h03);
    @(posedge pclk);
    chk(io_oe, 32'hF3);
    chk(io_o & 8'h03, 32'h02);
    poll(`MAC_IO_IN, 32'h0C, 32'h0C, 0);
    apb(1'b1, `MAC_IO_TRIG, 32'h04);
    apb(1'b1, `MAC_TRIG_ST, 32'h04);
    io_in <= 8'hA1;
    poll(`MAC_TRIG_ST, 32'h04, 32'h00, 3);
    io_in <= 8'hA5;
    poll(`MAC_TRIG_ST, 32'h04, 32'h04, 10);
    apb(1'b1, `MAC_STEP_CFG, 32'h0000_F000);
    poll(`MAC_STEP_CFG, 32'hFFFF, 32'hF000, 0);
    chk(step_inh, 32'hE);
    chk(io_o[7:4], 32'hE);
    stop_test;
  end
endmodule // mac_axis_ctrl_tb_top
